/* File: hdl/srb_defines.svh */
`ifndef SRB_DEFINES_SVH
`define SRB_DEFINES_SVH

// Auxiliary settings register layout
`define SRB_AUX_BYP_BIT    7
`define SRB_AUX_MAP_MSB    6
`define SRB_AUX_MAP_LSB    5
`define SRB_AUX_EXT_BIT    4
`define SRB_AUX_KEEP_BIT   3
`define SRB_AUX_SET_BIT    2
`define SRB_AUX_PAV_MSB    1
`define SRB_AUX_PAV_LSB    0
`define SRB_AUX_RESET      8'h02
`define SRB_AUX_WR_MASK    8'hfb

// Battery monitor control register layout
`define SRB_BMC_STAT_BIT   5
`define SRB_BMC_RANGE_BIT  4
`define SRB_BMC_CODE_MSB   3
`define SRB_BMC_CODE_LSB   0
`define SRB_BMC_RESET      8'h02
`define SRB_BMC_WR_MASK    8'h1f

// Gain map codes
`define SRB_MAP_INTERNAL   2'h0
`define SRB_MAP_9DB        2'h1
`define SRB_MAP_12DB       2'h2

// Amplifier supply codes: 2.0 V, 2.2 V, 2.4 V
`define SRB_PAV_2V0        2'h0
`define SRB_PAV_2V2        2'h1
`define SRB_PAV_2V4        2'h2

// Threshold ladders in mV
`define SRB_THR_BASE_HIGH  12'h9f6
`define SRB_THR_BASE_LOW   12'h6a4
`define SRB_THR_STEP_HIGH  12'h04b
`define SRB_THR_STEP_LOW   12'h032

// Frontend pin configurations
`define SRB_FE_CFG_NONE    2'h0
`define SRB_FE_CFG_ONE     2'h1
`define SRB_FE_CFG_TWO     2'h2
`define SRB_FE_CFG_THREE   2'h3

`endif

/* File: hdl/srb_pkg.sv */
package srb_pkg;

	typedef enum logic [2:0] {
		SRB_IDLE   = 3'h0,
		SRB_TRANSMIT_PREPARE_STATE = 3'h1,
		SRB_TX     = 3'h3,
		SRB_RX     = 3'h2,
		SRB_SLEEP  = 3'h6
	} srb_radio_state_t;

	typedef enum logic [1:0] {
		SRB_CAL_IDLE = 2'h0,
		SRB_CAL_WAIT = 2'h1,
		SRB_CAL_GO   = 2'h3
	} srb_cal_state_t;

endpackage : srb_pkg

/* File: hdl/srb_sync2.sv */
module srb_sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk_in,
	input  wire logic         sys_rst_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	import srb_pkg::*;

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] sync_r;
	logic [W-1:0] sync_nxt;

	// First stage feeds only the second stage
	always_comb begin
		meta_nxt = async_in;
		sync_nxt = meta_r;
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign sync_out = sync_r;

endmodule : srb_sync2

/* File: hdl/srb_trx_supply.sv */
module srb_trx_supply (
	input  wire logic                     sys_clk_in,
	input  wire logic                     sys_rst_in,
	input  wire srb_pkg::srb_radio_state_t radio_state_in,
	input  wire logic                     analog_supply_keep_on_in,
	input  wire logic                     external_analog_supply_in,
	input  wire logic                     analog_supply_settled_in,
	output logic                          analog_regulator_out,
	output logic                          cal_start_out
);
	import srb_pkg::*;

	logic             reg_on_r;
	logic             reg_on_nxt;
	logic             cal_start_r;
	logic             cal_start_nxt;
	srb_radio_state_t prev_r;
	srb_radio_state_t prev_nxt;
	srb_cal_state_t   cal_r;
	srb_cal_state_t   cal_nxt;
	logic             active;
	logic             leave_idle;

	always_comb begin
		active = (radio_state_in == SRB_TRANSMIT_PREPARE_STATE) || (radio_state_in == SRB_TX) ||
			(radio_state_in == SRB_RX);
		leave_idle = (prev_r == SRB_IDLE) &&
			((radio_state_in == SRB_TRANSMIT_PREPARE_STATE) || (radio_state_in == SRB_RX));
		reg_on_nxt = !external_analog_supply_in && (radio_state_in != SRB_SLEEP) &&
			(active || analog_supply_keep_on_in);
		prev_nxt = radio_state_in;
		cal_nxt = cal_r;
		cal_start_nxt = 1'b0;
		case (cal_r)
			SRB_CAL_IDLE: begin
				if (leave_idle) begin
					cal_nxt = SRB_CAL_WAIT;
				end
			end
			SRB_CAL_WAIT: begin
				// Calibration waits for the regulator or the external supply, and for the settled flag
				if (!active) begin
					cal_nxt = SRB_CAL_IDLE;
				end else if ((reg_on_r || external_analog_supply_in) &&
					analog_supply_settled_in) begin
					cal_nxt = SRB_CAL_GO;
				end
			end
			SRB_CAL_GO: begin
				cal_start_nxt = 1'b1;
				cal_nxt = SRB_CAL_IDLE;
			end
			default: begin
				cal_nxt = SRB_CAL_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			reg_on_r    <= 1'b0;
			cal_start_r <= 1'b0;
			prev_r      <= SRB_IDLE;
			cal_r       <= SRB_CAL_IDLE;
		end else begin
			reg_on_r    <= reg_on_nxt;
			cal_start_r <= cal_start_nxt;
			prev_r      <= prev_nxt;
			cal_r       <= cal_nxt;
		end
	end

	assign analog_regulator_out = reg_on_r;
	assign cal_start_out        = cal_start_r;

	a_reg_sleep_off: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		(radio_state_in == SRB_SLEEP) |=> !reg_on_r)
		else $error("analog regulator on in sleep");
	a_reg_ext_off: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		external_analog_supply_in |=> !reg_on_r)
		else $error("analog regulator on with external supply");
	a_cal_after_reg: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
		cal_start_r |-> $past(reg_on_r, 2) || $past(external_analog_supply_in, 2))
		else $error("calibration started before supply");

endmodule : srb_trx_supply

/* File: hdl/srb_supply_ctrl.sv */
// Behaviour
// - Digital regulator stays on, off only when both transceivers sleep.
// - Analog regulator on only in transmit-prepare, transmit or receive of its transceiver, or in idle with keep-on set.
// - Keep-on bit holds analog regulator on except in sleep or with the external-supply bit set; resets to zero.
// - Auxiliary register bit 2 reads whether the analog supply has settled.
// - External-supply bit keeps the internal analog regulator off in all states.
// - No control exists to turn off the digital regulator beyond deep sleep.
// - Bypass-enable bit allows external amplifier bypass via frontend pins; resets off.
// - Two-bit gain map: internal, 9 dB back-off, 12 dB back-off.
// - Bypass bit set with gain map zero drives the bypass pin pattern.
// - Amplifier voltage code 0/1/2 selects 2.0/2.2/2.4 V; resets to 2.
// - Threshold code and range bit select threshold; 75 mV or 50 mV steps.
// - Status bit reads one while supply is above threshold, zero below.
// - Battery monitor inactive while both transceivers sleep.
// - Supply drop raises low-supply status in each non-sleeping transceiver.
// - Only a one-to-zero status transition raises the low-supply event.
// - Threshold resets to code 2, low range, i.e. 1.8 V.
// - Control register: bits 7:6 zero, status 5, range 4, code 3:0.
// - Leaving idle turns analog regulator on, unless the external-supply bit is set, before calibration starts.
`include "srb_defines.svh"

module srb_supply_ctrl (
	input  wire logic                      sys_clk_in,
	input  wire logic                      sys_rst_in,
	input  wire srb_pkg::srb_radio_state_t sub_ghz_state_in,
	input  wire srb_pkg::srb_radio_state_t high_band_state_in,
	input  wire logic [1:0]                sub_ghz_frontend_pin_config_in,
	input  wire logic [1:0]                high_band_frontend_pin_config_in,
	input  wire logic [1:0]                auxiliary_settings_wr_in,
	input  wire logic                      battery_monitor_control_wr_in,
	input  wire logic [7:0]                wr_data_in,
	input  wire logic [1:0]                analog_supply_settled_in,
	input  wire logic                      supply_threshold_monitor_in,
	input  wire logic [1:0]                interrupt_mask_in,
	input  wire logic [1:0]                interrupt_status_clear_in,
	output logic                           digital_core_regulator_out,
	output logic                           sub_ghz_analog_regulator_out,
	output logic                           high_band_analog_regulator_out,
	output logic [1:0]                     cal_start_out,
	output logic [7:0]                     sub_ghz_auxiliary_settings_out,
	output logic [7:0]                     high_band_auxiliary_settings_out,
	output logic [7:0]                     battery_monitor_control_out,
	output logic                           supply_threshold_monitor_en_out,
	output logic [3:0]                     threshold_code_out,
	output logic                           threshold_high_range_out,
	output logic [11:0]                    threshold_mv_out,
	output logic [3:0]                     amplifier_voltage_select_out,
	output logic [3:0]                     gain_map_select_out,
	output logic [1:0]                     external_amp_bypass_active_out,
	output logic [1:0]                     frontend_control_a_out,
	output logic [1:0]                     frontend_control_b_out,
	output logic [1:0]                     low_supply_event_out,
	output logic [1:0]                     irq_out
);
	import srb_pkg::*;

	function automatic logic [11:0] thr_mv(input logic [3:0] code, input logic hr);
		logic [11:0] c;
		c = {8'h00, code};
		if (hr) begin
			thr_mv = `SRB_THR_BASE_HIGH + c * `SRB_THR_STEP_HIGH;
		end else begin
			thr_mv = `SRB_THR_BASE_LOW + c * `SRB_THR_STEP_LOW;
		end
	endfunction : thr_mv

	// Returns {a, b} for the frontend pins
	function automatic logic [1:0] fe_pins(input logic [1:0] cfg,
		input srb_radio_state_t st, input logic byp);
		fe_pins = 2'h0;
		if (cfg != `SRB_FE_CFG_NONE) begin
			case (st)
				SRB_TX: begin
					fe_pins = (cfg == `SRB_FE_CFG_ONE) ? 2'h2 : 2'h3;
				end
				SRB_RX: begin
					if (!byp) begin
						fe_pins = 2'h1;
					end else if (cfg == `SRB_FE_CFG_ONE) begin
						fe_pins = 2'h3;
					end else if (cfg == `SRB_FE_CFG_TWO) begin
						fe_pins = 2'h2;
					end else begin
						fe_pins = 2'h0;
					end
				end
				default: begin
					fe_pins = 2'h0;
				end
			endcase
		end
	endfunction : fe_pins

	srb_radio_state_t st [2];
	logic [1:0]       fe_cfg [2];
	logic [1:0]       settled_s;
	logic             cmp_s;
	logic [1:0]       ana_on;
	logic [1:0]       cal_go;

	logic [7:0]  aux_r [2];
	logic [7:0]  aux_nxt [2];
	logic [4:0]  bmc_r;
	logic [4:0]  bmc_nxt;
	logic        above_r;
	logic        above_nxt;
	logic        mon_en_r;
	logic        mon_en_nxt;
	logic        dig_r;
	logic        dig_nxt;
	logic [1:0]  stat_r;
	logic [1:0]  stat_nxt;
	logic [1:0]  irq_r;
	logic [1:0]  irq_nxt;
	logic [7:0]  rd_r [3];
	logic [7:0]  rd_nxt [3];
	logic [11:0] mv_r;
	logic [11:0] mv_nxt;
	logic [3:0]  pav_r;
	logic [3:0]  pav_nxt;
	logic [3:0]  map_r;
	logic [3:0]  map_nxt;
	logic [1:0]  byp_r;
	logic [1:0]  byp_nxt;
	logic [1:0]  fea_r;
	logic [1:0]  fea_nxt;
	logic [1:0]  feb_r;
	logic [1:0]  feb_nxt;
	logic        deep;
	logic        fall;
	logic [1:0]  pins;

	assign st[0]     = sub_ghz_state_in;
	assign st[1]     = high_band_state_in;
	assign fe_cfg[0] = sub_ghz_frontend_pin_config_in;
	assign fe_cfg[1] = high_band_frontend_pin_config_in;

	srb_sync2 #(.W(3)) i_srb_sync2 (
		.sys_clk_in (sys_clk_in),
		.sys_rst_in (sys_rst_in),
		.async_in   ({supply_threshold_monitor_in, analog_supply_settled_in}),
		.sync_out   ({cmp_s, settled_s})
	);

	for (genvar g = 0; g < 2; g++) begin : g_trx
		srb_trx_supply i_srb_trx_supply (
			.sys_clk_in                (sys_clk_in),
			.sys_rst_in                (sys_rst_in),
			.radio_state_in            (st[g]),
			.analog_supply_keep_on_in  (aux_r[g][`SRB_AUX_KEEP_BIT]),
			.external_analog_supply_in (aux_r[g][`SRB_AUX_EXT_BIT]),
			.analog_supply_settled_in  (settled_s[g]),
			.analog_regulator_out      (ana_on[g]),
			.cal_start_out             (cal_go[g])
		);
	end

	// Battery monitor and low-supply events
	always_comb begin
		deep = (st[0] == SRB_SLEEP) && (st[1] == SRB_SLEEP);
		// The only off path; no register bit reaches this enable
		dig_nxt = !deep;
		mon_en_nxt = !deep;
		// Status freezes while the comparator is unpowered
		above_nxt = mon_en_r ? cmp_s : above_r;
		// Reset value zero means a supply never above the threshold gives no edge
		fall = mon_en_r && above_r && !cmp_s;
		for (int i = 0; i < 2; i++) begin
			// A fresh event wins over a clear in the same cycle
			stat_nxt[i] = (fall && (st[i] != SRB_SLEEP)) ||
				(stat_r[i] && !interrupt_status_clear_in[i]);
			irq_nxt[i] = stat_nxt[i] && interrupt_mask_in[i];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			dig_r    <= 1'b1;
			mon_en_r <= 1'b1;
			above_r  <= 1'b0;
			stat_r   <= 2'h0;
			irq_r    <= 2'h0;
		end else begin
			dig_r    <= dig_nxt;
			mon_en_r <= mon_en_nxt;
			above_r  <= above_nxt;
			stat_r   <= stat_nxt;
			irq_r    <= irq_nxt;
		end
	end

	// Register writes and read-back
	always_comb begin
		bmc_nxt = bmc_r;
		if (battery_monitor_control_wr_in) begin
			bmc_nxt = wr_data_in[4:0] & 5'(`SRB_BMC_WR_MASK);
		end
		for (int i = 0; i < 2; i++) begin
			aux_nxt[i] = aux_r[i];
			if (auxiliary_settings_wr_in[i]) begin
				aux_nxt[i] = wr_data_in & `SRB_AUX_WR_MASK;
			end
			rd_nxt[i] = aux_r[i];
			rd_nxt[i][`SRB_AUX_SET_BIT] = settled_s[i];
		end
		rd_nxt[2] = {2'h0, above_r, bmc_r};
		mv_nxt = thr_mv(bmc_r[`SRB_BMC_CODE_MSB:`SRB_BMC_CODE_LSB],
			bmc_r[`SRB_BMC_RANGE_BIT]);
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			aux_r[0] <= `SRB_AUX_RESET;
			aux_r[1] <= `SRB_AUX_RESET;
			bmc_r    <= 5'(`SRB_BMC_RESET);
			rd_r[0]  <= `SRB_AUX_RESET;
			rd_r[1]  <= `SRB_AUX_RESET;
			rd_r[2]  <= `SRB_BMC_RESET;
			mv_r     <= `SRB_THR_BASE_LOW + `SRB_THR_STEP_LOW + `SRB_THR_STEP_LOW;
		end else begin
			aux_r[0] <= aux_nxt[0];
			aux_r[1] <= aux_nxt[1];
			bmc_r    <= bmc_nxt;
			rd_r[0]  <= rd_nxt[0];
			rd_r[1]  <= rd_nxt[1];
			rd_r[2]  <= rd_nxt[2];
			mv_r     <= mv_nxt;
		end
	end

	// Frontend pins and per-transceiver settings
	always_comb begin
		pins = 2'h0;
		for (int i = 0; i < 2; i++) begin
			// Bypass only without an AGC back-off mapping
			byp_nxt[i] = aux_r[i][`SRB_AUX_BYP_BIT] &&
				(aux_r[i][`SRB_AUX_MAP_MSB:`SRB_AUX_MAP_LSB] == `SRB_MAP_INTERNAL);
			pins = fe_pins(fe_cfg[i], st[i], byp_nxt[i]);
			fea_nxt[i] = pins[1];
			feb_nxt[i] = pins[0];
			pav_nxt[i*2 +: 2] = aux_r[i][`SRB_AUX_PAV_MSB:`SRB_AUX_PAV_LSB];
			map_nxt[i*2 +: 2] = aux_r[i][`SRB_AUX_MAP_MSB:`SRB_AUX_MAP_LSB];
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (sys_rst_in) begin
			byp_r <= 2'h0;
			fea_r <= 2'h0;
			feb_r <= 2'h0;
			pav_r <= {`SRB_PAV_2V4, `SRB_PAV_2V4};
			map_r <= {`SRB_MAP_INTERNAL, `SRB_MAP_INTERNAL};
		end else begin
			byp_r <= byp_nxt;
			fea_r <= fea_nxt;
			feb_r <= feb_nxt;
			pav_r <= pav_nxt;
			map_r <= map_nxt;
		end
	end

	assign digital_core_regulator_out       = dig_r;
	assign sub_ghz_analog_regulator_out     = ana_on[0];
	assign high_band_analog_regulator_out   = ana_on[1];
	assign cal_start_out                    = cal_go;
	assign sub_ghz_auxiliary_settings_out   = rd_r[0];
	assign high_band_auxiliary_settings_out = rd_r[1];
	assign battery_monitor_control_out      = rd_r[2];
	assign supply_threshold_monitor_en_out  = mon_en_r;
	assign threshold_code_out               = bmc_r[`SRB_BMC_CODE_MSB:`SRB_BMC_CODE_LSB];
	assign threshold_high_range_out         = bmc_r[`SRB_BMC_RANGE_BIT];
	assign threshold_mv_out                 = mv_r;
	assign amplifier_voltage_select_out     = pav_r;
	assign gain_map_select_out              = map_r;
	assign external_amp_bypass_active_out   = byp_r;
	assign frontend_control_a_out           = fea_r;
	assign frontend_control_b_out           = feb_r;
	assign low_supply_event_out             = stat_r;
	assign irq_out                          = irq_r;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (sys_rst_in);

	sequence s_deep;
		(st[0] == SRB_SLEEP) && (st[1] == SRB_SLEEP);
	endsequence

	sequence s_fall(int i);
		mon_en_r && above_r && !cmp_s && (st[i] != SRB_SLEEP);
	endsequence

	a_dig_reg_deep: assert property (s_deep |=> !dig_r && !mon_en_r)
		else $error("digital regulator on in deep sleep");
	a_dig_reg_awake: assert property (!deep |=> dig_r)
		else $error("digital regulator off while awake");
	a_mon_sleep: assert property (s_deep ##1 s_deep |=> !mon_en_r && $stable(above_r))
		else $error("monitor active in deep sleep");
	a_status_track: assert property (mon_en_r |=> above_r == $past(cmp_s))
		else $error("status does not follow comparator");
	a_fall_sets: assert property (s_fall(0) |=> stat_r[0] ##1 1'b1)
		else $error("low-supply event lost");
	a_fall_sets_hb: assert property (s_fall(1) |=> stat_r[1])
		else $error("low-supply event lost on high band");
	a_edge_only: assert property ($rose(stat_r[0]) |-> $past(above_r) && !above_r)
		else $error("event raised without falling status");
	a_reset_thr: assert property ($fell(sys_rst_in) |-> bmc_r == 5'h02 && !above_r)
		else $error("threshold reset value wrong");
	a_read_fmt: assert property (rd_r[2][7:6] == 2'h0 &&
		$past(above_r) == rd_r[2][`SRB_BMC_STAT_BIT])
		else $error("control register read format wrong");
	a_bypass_pins: assert property (byp_nxt[0] && st[0] == SRB_RX &&
		fe_cfg[0] == `SRB_FE_CFG_ONE |=> fea_r[0] && feb_r[0])
		else $error("bypass pattern not driven");
	a_irq_gate: assert property (irq_r[0] |-> stat_r[0] && $past(interrupt_mask_in[0]))
		else $error("interrupt without masked status");

endmodule : srb_supply_ctrl

/* File: tb/srb_supply_ctrl_tb_top.sv */
module srb_supply_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import srb_pkg::*;

	typedef struct packed {
		srb_radio_state_t s0;
		srb_radio_state_t s1;
		logic [7:0]       a0;
		logic [7:0]       a1;
		logic [2:0]       exp;
	} srb_row_t;

	logic             sys_clk_in = 1'b0;
	logic             sys_rst_in = 1'b1;
	srb_radio_state_t st0      = SRB_IDLE;
	srb_radio_state_t st1      = SRB_IDLE;
	logic [1:0]       aux_wr   = 2'h0;
	logic             bmc_wr   = 1'b0;
	logic [7:0]       wdata    = 8'h00;
	logic [1:0]       settled  = 2'h0;
	logic             comp     = 1'b0;
	logic [1:0]       mask     = 2'h1;
	logic [1:0]       clr      = 2'h0;
	logic [1:0]       fe0      = 2'h0;
	logic [1:0]       fe1      = 2'h0;
	logic             dig;
	logic             ana0;
	logic             ana1;
	logic [1:0]       cal;
	logic [7:0]       aux0;
	logic [7:0]       aux1;
	logic [7:0]       bmc;
	logic             mon_en;
	logic [3:0]       code;
	logic             range;
	logic [11:0]      mv;
	logic [3:0]       pav;
	logic [3:0]       gmap;
	logic [1:0]       byp;
	logic [1:0]       fea;
	logic [1:0]       feb;
	logic [1:0]       evt;
	logic [1:0]       irq;
	int               err_count = 0;
	int               compares  = 0;
	int               i;
	logic [1:0]       k2;
	logic [3:0]       c4;
	logic             r1;

	// Ordinary regulator cases: {digital, sub-GHz analog, high-band analog}
	srb_row_t rows [9] = '{
		'{SRB_IDLE,   SRB_IDLE,  8'h00, 8'h00, 3'h4},
		'{SRB_SLEEP,  SRB_IDLE,  8'h00, 8'h00, 3'h4},
		'{SRB_SLEEP,  SRB_SLEEP, 8'h00, 8'h00, 3'h0},
		'{SRB_TRANSMIT_PREPARE_STATE, SRB_RX,    8'h00, 8'h00, 3'h7},
		'{SRB_TX,     SRB_SLEEP, 8'h00, 8'h00, 3'h6},
		'{SRB_IDLE,   SRB_IDLE,  8'h08, 8'h08, 3'h7},
		'{SRB_SLEEP,  SRB_IDLE,  8'h08, 8'h08, 3'h5},
		'{SRB_TX,     SRB_RX,    8'h10, 8'h00, 3'h5},
		'{SRB_IDLE,   SRB_TX,    8'h18, 8'h10, 3'h4}
	};

	always #50 sys_clk_in = ~sys_clk_in;

	srb_supply_ctrl i_srb_supply_ctrl (
		.sys_clk_in                       (sys_clk_in),
		.sys_rst_in                       (sys_rst_in),
		.sub_ghz_state_in                 (st0),
		.high_band_state_in               (st1),
		.sub_ghz_frontend_pin_config_in   (fe0),
		.high_band_frontend_pin_config_in (fe1),
		.auxiliary_settings_wr_in         (aux_wr),
		.battery_monitor_control_wr_in    (bmc_wr),
		.wr_data_in                       (wdata),
		.analog_supply_settled_in         (settled),
		.supply_threshold_monitor_in      (comp),
		.interrupt_mask_in                (mask),
		.interrupt_status_clear_in        (clr),
		.digital_core_regulator_out       (dig),
		.sub_ghz_analog_regulator_out     (ana0),
		.high_band_analog_regulator_out   (ana1),
		.cal_start_out                    (cal),
		.sub_ghz_auxiliary_settings_out   (aux0),
		.high_band_auxiliary_settings_out (aux1),
		.battery_monitor_control_out      (bmc),
		.supply_threshold_monitor_en_out  (mon_en),
		.threshold_code_out               (code),
		.threshold_high_range_out         (range),
		.threshold_mv_out                 (mv),
		.amplifier_voltage_select_out     (pav),
		.gain_map_select_out              (gmap),
		.external_amp_bypass_active_out   (byp),
		.frontend_control_a_out           (fea),
		.frontend_control_b_out           (feb),
		.low_supply_event_out             (evt),
		.irq_out                          (irq)
	);

	task automatic give_verdict;
		if (err_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_in);
		#10;
	endtask : cyc

	// Strobe held for exactly one edge; sel 1/2 picks an aux register, 3 the control
	task automatic wr(input int sel, input logic [7:0] d);
		@(posedge sys_clk_in);
		#10;
		aux_wr = {sel == 2, sel == 1};
		bmc_wr = (sel == 3);
		wdata  = d;
		@(posedge sys_clk_in);
		#10;
		aux_wr = 2'h0;
		bmc_wr = 1'b0;
	endtask : wr

	initial begin
		#200000;
		err_count++;
		give_verdict();
	end

	initial begin
		cyc(3);
		sys_rst_in = 1'b0;
		chk({dig, ana0, ana1}, 3'h4);
		chk(aux0, 8'h02);
		chk(aux1, 8'h02);
		chk(bmc, 8'h02);
		chk(mv, 12'h708);
		chk({pav, gmap, byp}, 10'h280);
		chk({mon_en, fea, feb}, 5'h10);
		// Supply starts below threshold, status never high: no event
		cyc(6);
		chk(evt, 2'h0);
		for (i = 0; i < 9; i++) begin
			wr(1, rows[i].a0);
			wr(2, rows[i].a1);
			st0 = rows[i].s0;
			st1 = rows[i].s1;
			cyc(4);
			chk({dig, ana0, ana1}, rows[i].exp);
		end
		st0 = SRB_IDLE;
		st1 = SRB_IDLE;
		wr(1, 8'hcd);
		cyc(3);
		chk(aux0, 8'hc9);
		chk(byp, 2'h0);
		for (i = 0; i < 3; i++) begin
			k2 = i[1:0];
			wr(1, {1'b0, k2, 3'h0, k2});
			cyc(3);
			chk({gmap, pav}, {2'h0, k2, 2'h0, k2});
		end
		wr(1, 8'h80);
		wr(2, 8'ha0);
		cyc(3);
		chk(byp, 2'h1);
		// Every threshold code in both ranges; status stays low, bits 7:5 ignored
		for (i = 0; i < 32; i++) begin
			c4 = i[3:0];
			r1 = i[4];
			wr(3, {3'h7, r1, c4});
			cyc(3);
			chk({code, range}, {c4, r1});
			chk(mv, r1 ? 12'd2550 + 12'd75 * c4 : 12'd1700 + 12'd50 * c4);
			chk(bmc, {3'h0, r1, c4});
		end
		chk(evt, 2'h0);
		wr(3, 8'h02);
		comp = 1'b1;
		cyc(6);
		chk(bmc, 8'h22);
		comp = 1'b0;
		cyc(6);
		chk({evt, irq}, 4'hd);
		chk(bmc, 8'h02);
		clr = 2'h3;
		cyc(2);
		clr = 2'h0;
		cyc(4);
		chk(evt, 2'h0);
		// One transceiver asleep: only the other raises the event
		st1 = SRB_SLEEP;
		comp = 1'b1;
		cyc(6);
		comp = 1'b0;
		cyc(6);
		chk(evt, 2'h1);
		clr = 2'h3;
		comp = 1'b1;
		cyc(2);
		clr = 2'h0;
		st0 = SRB_SLEEP;
		cyc(6);
		chk({dig, mon_en}, 2'h0);
		comp = 1'b0;
		cyc(6);
		chk(evt, 2'h0);
		// Let the restored supply pass the synchroniser before waking,
		// else a stale low sample meets the frozen high status
		comp = 1'b1;
		cyc(3);
		st0 = SRB_IDLE;
		st1 = SRB_IDLE;
		cyc(6);
		chk(evt, 2'h0);
		wr(1, 8'h00);
		settled = 2'h1;
		cyc(3);
		chk(aux0[2], 1'b1);
		st0 = SRB_TRANSMIT_PREPARE_STATE;
		i = 0;
		while (i < 30 && cal[0] !== 1'b1) begin
			cyc(1);
			i++;
		end
		chk(cal[0], 1'b1);
		chk(ana0, 1'b1);
		// Frontend pins: bypass in configurations 1 and 3, then transmit
		fe0 = 2'h1;
		fe1 = 2'h3;
		wr(1, 8'h80);
		wr(2, 8'h80);
		st0 = SRB_RX;
		st1 = SRB_RX;
		cyc(3);
		chk({fea, feb}, 4'h5);
		fe1 = 2'h2;
		st0 = SRB_TX;
		cyc(3);
		chk({fea, feb}, 4'hc);
		give_verdict();
	end

endmodule : srb_supply_ctrl_tb_top
